// ==== rtl/pmt_pkg.sv ====
package pmt_pkg;
  localparam int PMT_DEPTH = 1024;
  localparam int PMT_AW = 10;
  localparam int PMT_DW = 14;
  localparam int PMT_HIW = 6;
  localparam logic [9:0] PMT_RESET_VECTOR = 10'h000;
  localparam logic [7:0] PMT_HIGH_RESET = 8'h00;
  localparam logic [1:0] PMT_PAGE_HI_LAST = 2'h3;
  localparam int PMT_TABLE_CYCLES = 2;
  localparam logic [1:0] PMT_WAIT_FIRST = 2'h1;
  typedef enum logic [1:0] {
    PMT_IDLE = 2'b00,
    PMT_FETCH = 2'b01,
    PMT_DONE = 2'b10
  } pmt_state_t;
endpackage

// ==== rtl/pmt_rd_if.sv ====
`timescale 1ns/1ps
interface pmt_rd_if;
  logic [9:0] addr;
  logic [13:0] data;
  modport core (output addr, input data);
  modport mem (input addr, output data);
endinterface

// ==== rtl/pmt_array.sv ====
`timescale 1ns/1ps
module pmt_array (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [13:0] wr_data,
  pmt_rd_if.mem rd
);
  logic [13:0] mem [0:pmt_pkg::PMT_DEPTH-1];
  logic [13:0] rd_q;

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_q <= mem[rd.addr];
  end
  assign rd.data = rd_q;
endmodule

// ==== rtl/pmt_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Program store is 1024 words of 14 bits holding code and tables.
// RULE2 - Fetch uses the program counter, table reads the table pointer.
// RULE3 - Reset puts the program counter at location zero.
// RULE4 - Table pointer low and high bytes together form a paged address.
// RULE5 - A table read can reach every word of the store.
// RULE6 - Low eight bits of the word go to the named data register.
// RULE7 - Upper bits of the word go to the table high byte register.
// RULE8 - High byte register bits with no word bit read as zero.
// RULE9 - High byte register changes only on a table read.
// RULE10 - Each table read takes two instruction cycles.
// RULE11 - Programming moves data both ways on one data line plus clock.
// RULE12 - The board leaves the programming pins undriven meanwhile.
// RULE13 - Debug data pin is two-way; debug clock is input only.
// RULE14 - Shared pin functions are off while debugging.
// RULE15 - Debug pins double as the programming data and clock pins.
// RULE16 - Only the low pc byte is software accessible; upper by flow only.
// RULE17 - High byte register holds until next table read, zero at reset.
module pmt_top (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cyc_en,
  input wire logic pc_advance,
  input wire logic pc_jump,
  input wire logic [9:0] pc_target,
  input wire logic pc_low_wr,
  input wire logic [7:0] pc_low_wdata,
  input wire logic [7:0] tbl_ptr_low,
  input wire logic [1:0] tbl_ptr_high,
  input wire logic tbl_rd_req,
  input wire logic tbl_rd_last_page,
  input wire logic [6:0] tbl_dest,
  input wire logic debug_en,
  input wire logic prog_en,
  input wire logic prog_wr,
  input wire logic [9:0] prog_addr,
  input wire logic [13:0] prog_wdata,
  input wire logic debug_serial_data_in,
  input wire logic debug_serial_clock,
  input wire logic pin_func_out,
  input wire logic pin_func_oe_n,
  input wire logic prog_sda_out,
  input wire logic prog_sda_oe_n,
  output logic [9:0] pc,
  output logic [7:0] pc_low_byte,
  output logic [13:0] instr,
  output logic tbl_busy,
  output logic dm_wr,
  output logic [6:0] dm_addr,
  output logic [7:0] dm_wdata,
  output logic [7:0] table_high_byte,
  output logic [13:0] prog_rdata,
  output logic pin_data_out,
  output logic pin_data_oe_n,
  output logic debug_clk_seen
);
  ////////////////////////////////////////////////////////////////////
  pmt_rd_if rdp ();
  pmt_pkg::pmt_state_t state;
  logic [9:0] tbl_addr;
  logic [6:0] dest_q;
  logic [9:0] rd_addr;

  function automatic logic [9:0] pmt_tbl_addr(input logic last,
      input logic [1:0] hi, input logic [7:0] lo);
    pmt_tbl_addr = last ? {pmt_pkg::PMT_PAGE_HI_LAST, lo} : {hi, lo};
  endfunction

  // Single read port: table/programming win the port, fetch stalls then
  always_comb begin
    if (prog_en) begin
      rd_addr = prog_addr;
    end else if (state != pmt_pkg::PMT_IDLE) begin
      rd_addr = tbl_addr; // [RULE2] [RULE5]
    end else begin
      rd_addr = pc; // [RULE2]
    end
  end
  assign rdp.addr = rd_addr;

  pmt_array u_array (
    .core_clk(core_clk),
    .wr_en(prog_en && prog_wr), // [RULE1] [RULE11]
    .wr_addr(prog_addr),
    .wr_data(prog_wdata),
    .rd(rdp)
  );

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc <= pmt_pkg::PMT_RESET_VECTOR; // [RULE3]
    end else if (cyc_en && !prog_en && state == pmt_pkg::PMT_IDLE) begin
      if (pc_jump) begin
        pc <= pc_target; // [RULE16]
      end else if (pc_low_wr) begin
        pc <= {pc[9:8], pc_low_wdata}; // [RULE16]
      end else if (pc_advance && !tbl_rd_req) begin
        pc <= pc + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc_low_byte <= 8'h00;
      instr <= 14'h0000;
      prog_rdata <= 14'h0000;
    end else begin
      pc_low_byte <= pc[7:0]; // [RULE16]
      if (state == pmt_pkg::PMT_IDLE && !prog_en) begin
        instr <= rdp.data;
      end
      if (prog_en) begin
        prog_rdata <= rdp.data; // [RULE11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Two instruction cycles: FETCH then DONE, each one cyc_en long
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= pmt_pkg::PMT_IDLE;
      tbl_addr <= 10'h000;
      dest_q <= 7'h00;
    end else if (cyc_en && !prog_en) begin
      case (state)
        pmt_pkg::PMT_IDLE: begin
          if (tbl_rd_req) begin
            tbl_addr <= pmt_tbl_addr(tbl_rd_last_page, tbl_ptr_high,
                tbl_ptr_low); // [RULE4]
            dest_q <= tbl_dest;
            state <= pmt_pkg::PMT_FETCH;
          end
        end
        pmt_pkg::PMT_FETCH: begin
          state <= pmt_pkg::PMT_DONE; // [RULE10]
        end
        default: begin
          state <= pmt_pkg::PMT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tbl_busy <= 1'b0;
      dm_wr <= 1'b0;
      dm_addr <= 7'h00;
      dm_wdata <= 8'h00;
      table_high_byte <= pmt_pkg::PMT_HIGH_RESET; // [RULE17]
    end else begin
      tbl_busy <= state != pmt_pkg::PMT_IDLE ||
          (cyc_en && tbl_rd_req && !prog_en);
      dm_wr <= 1'b0;
      if (cyc_en && !prog_en && state == pmt_pkg::PMT_FETCH) begin
        dm_wr <= 1'b1;
        dm_addr <= dest_q;
        dm_wdata <= rdp.data[7:0]; // [RULE6]
        table_high_byte <= {2'b00, rdp.data[13:8]}; // [RULE7] [RULE8] [RULE9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Shared data pin: programming/debug owns it, else the port function
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_data_out <= 1'b0;
      pin_data_oe_n <= 1'b1;
      debug_clk_seen <= 1'b0;
    end else begin
      debug_clk_seen <= debug_en && debug_serial_clock; // [RULE13]
      if (prog_en || debug_en) begin // [RULE14]
        pin_data_out <= prog_sda_out; // [RULE11] [RULE15]
        pin_data_oe_n <= prog_sda_oe_n; // [RULE13]
      end else begin
        pin_data_out <= pin_func_out;
        pin_data_oe_n <= pin_func_oe_n;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  sequence s_start;
    cyc_en && !prog_en && state == pmt_pkg::PMT_IDLE && tbl_rd_req;
  endsequence

  property p_pc_reset;
    @(posedge core_clk) srst |=> pc == 10'h000;
  endproperty
  a_pc_reset: assert property (p_pc_reset) else $error("pc not zero"); // [RULE3]

  sequence s_fetch_step;
    cyc_en && !prog_en && state == pmt_pkg::PMT_FETCH;
  endsequence

  // Counts instruction cycles of a table read; saturates so it cannot wrap
  logic [1:0] tbl_cyc_cnt;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tbl_cyc_cnt <= 2'h0;
    end else if (cyc_en && !prog_en) begin
      if (state == pmt_pkg::PMT_IDLE) begin
        tbl_cyc_cnt <= tbl_rd_req ? 2'h1 : 2'h0;
      end else if (tbl_cyc_cnt != 2'h3) begin
        tbl_cyc_cnt <= tbl_cyc_cnt + 2'h1;
      end
    end
  end

  property p_tbl_start;
    @(posedge core_clk) disable iff (srst)
      s_start |=> state == pmt_pkg::PMT_FETCH && tbl_busy;
  endproperty
  a_tbl_start: assert property (p_tbl_start) else $error("start"); // [RULE10]

  property p_two_cycles;
    @(posedge core_clk) disable iff (srst)
      s_fetch_step |=> dm_wr &&
      tbl_cyc_cnt == 2'(pmt_pkg::PMT_TABLE_CYCLES);
  endproperty
  a_two_cycles: assert property (p_two_cycles) else $error("tbl timing"); // [RULE10]

  property p_high_zero;
    @(posedge core_clk) disable iff (srst) table_high_byte[7:6] == 2'b00;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("hi bits"); // [RULE8]

  property p_high_hold;
    @(posedge core_clk) disable iff (srst)
      !$past(dm_wr) && !dm_wr |-> $stable(table_high_byte);
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("hi changed"); // [RULE9]

  property p_pc_during_tbl;
    @(posedge core_clk) disable iff (srst)
      state != pmt_pkg::PMT_IDLE |=> $stable(pc);
  endproperty
  a_pc_during_tbl: assert property (p_pc_during_tbl) else $error("pc moved"); // [RULE2]

  property p_low_wr;
    @(posedge core_clk) disable iff (srst)
      cyc_en && !prog_en && state == pmt_pkg::PMT_IDLE && !pc_jump &&
      pc_low_wr |=> pc == {$past(pc[9:8]), $past(pc_low_wdata)};
  endproperty
  a_low_wr: assert property (p_low_wr) else $error("pc low wr"); // [RULE16]

  property p_dest;
    @(posedge core_clk) disable iff (srst) dm_wr |-> dm_addr == dest_q;
  endproperty
  a_dest: assert property (p_dest) else $error("dest"); // [RULE6]

  property p_pin_own;
    @(posedge core_clk) disable iff (srst)
      prog_en |=> pin_data_oe_n == $past(prog_sda_oe_n);
  endproperty
  a_pin_own: assert property (p_pin_own) else $error("pin owner"); // [RULE14]
endmodule

// ==== tb/pmt_core_model.sv ====
`timescale 1ns/1ps
module pmt_core_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic prog_en,
  output logic cyc_en,
  output logic pin_func_oe_n
);
  logic [1:0] phase;
  // Four core clocks make one instruction cycle
  always_ff @(posedge core_clk) begin
    phase <= srst ? 2'h0 : phase + 2'h1;
    cyc_en <= !srst && (phase == 2'h3);
  end
  // Port logic lets go of the shared pin while programming runs
  assign pin_func_oe_n = prog_en;
endmodule

// ==== tb/program_memory_table_read_tb.sv ====
`timescale 1ns/1ps
module program_memory_table_read_tb;
  logic core_clk = 0, srst = 1, pc_advance = 0, pc_jump = 0, pc_low_wr = 0;
  logic tbl_rd_req = 0, tbl_rd_last_page = 0, debug_en = 0, prog_en = 0;
  logic prog_wr = 0, prog_sda_out = 0, prog_sda_oe_n = 1;
  logic debug_serial_clock = 0, pin_func_out = 0;
  logic [9:0] pc_target = 0, prog_addr = 0;
  logic [7:0] pc_low_wdata = 0, tbl_ptr_low = 0;
  logic [1:0] tbl_ptr_high = 0;
  logic [6:0] tbl_dest = 0;
  logic [13:0] prog_wdata = 0;
  logic cyc_en, pin_func_oe_n, tbl_busy, dm_wr, pin_data_out;
  logic pin_data_oe_n, debug_clk_seen;
  logic [9:0] pc;
  logic [7:0] pc_low_byte, dm_wdata, table_high_byte;
  logic [6:0] dm_addr;
  logic [13:0] instr, prog_rdata;
  int failures = 0, samples_checked = 0, cycs = 0, i;
  logic [9:0] ta [4] = '{10'h306, 10'h305, 10'h3FF, 10'h000};
  logic [13:0] tw [4] = '{14'h3F1A, 14'h000F, 14'h2A55, 14'h1234};

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (cyc_en) cycs++;

  pmt_core_model core (.core_clk, .srst, .prog_en, .cyc_en, .pin_func_oe_n);
  pmt_top dut (
    .core_clk(core_clk),
    .srst(srst),
    .cyc_en(cyc_en),
    .pc_advance(pc_advance),
    .pc_jump(pc_jump),
    .pc_target(pc_target),
    .pc_low_wr(pc_low_wr),
    .pc_low_wdata(pc_low_wdata),
    .tbl_ptr_low(tbl_ptr_low),
    .tbl_ptr_high(tbl_ptr_high),
    .tbl_rd_req(tbl_rd_req),
    .tbl_rd_last_page(tbl_rd_last_page),
    .tbl_dest(tbl_dest),
    .debug_en(debug_en),
    .prog_en(prog_en),
    .prog_wr(prog_wr),
    .prog_addr(prog_addr),
    .prog_wdata(prog_wdata),
    .debug_serial_data_in(1'b0),
    .debug_serial_clock(debug_serial_clock),
    .pin_func_out(pin_func_out),
    .pin_func_oe_n(pin_func_oe_n),
    .prog_sda_out(prog_sda_out),
    .prog_sda_oe_n(prog_sda_oe_n),
    .pc(pc),
    .pc_low_byte(pc_low_byte),
    .instr(instr),
    .tbl_busy(tbl_busy),
    .dm_wr(dm_wr),
    .dm_addr(dm_addr),
    .dm_wdata(dm_wdata),
    .table_high_byte(table_high_byte),
    .prog_rdata(prog_rdata),
    .pin_data_out(pin_data_out),
    .pin_data_oe_n(pin_data_oe_n),
    .debug_clk_seen(debug_clk_seen)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait; a hang counts as a mismatch
  task automatic await(input logic sig_is_high);
    if (!sig_is_high) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic on_cyc();
    for (i = 0; i < 20 && cyc_en !== 1'b1; i++) tick(1);
    await(i < 20);
    tick(1);
  endtask
  task automatic tbl_read(input logic [1:0] hi, input logic [7:0] lo,
      input logic last, input logic [13:0] word);
    int c0;
    // A new request is only taken once the previous read has let go
    for (i = 0; i < 20 && tbl_busy !== 1'b0; i++) tick(1);
    await(i < 20);
    tbl_ptr_high = hi;
    tbl_ptr_low = lo;
    tbl_rd_last_page = last;
    tbl_dest = lo[6:0];
    tbl_rd_req = 1;
    for (i = 0; i < 20 && tbl_busy !== 1'b1; i++) tick(1);
    await(i < 20);
    // The taking edge is the first of the two instruction cycles
    c0 = cycs - 1;
    tbl_rd_req = 0;
    for (i = 0; i < 20 && dm_wr !== 1'b1; i++) tick(1);
    await(i < 20);
    chk(14'(cycs - c0), 14'h0002);
    chk({7'h00, dm_addr}, {7'h00, lo[6:0]});
    chk({6'h00, dm_wdata}, {6'h00, word[7:0]});
    chk({6'h00, table_high_byte}, {8'h00, word[13:8]});
    tick(1);
    chk({13'h0000, dm_wr}, 14'h0000);
    $display("table read %h%h done", hi, lo);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_load();
    prog_en = 1;
    for (int k = 0; k < 4; k++) begin
      prog_addr = ta[k];
      prog_wdata = tw[k];
      prog_wr = 1;
      tick(1);
    end
    prog_wr = 0;
    for (int k = 0; k < 4; k++) begin
      prog_addr = ta[k];
      tick(2);
      chk(prog_rdata, tw[k]);
    end
    prog_en = 0;
    tick(3);
    chk(instr, 14'h1234);
    $display("load and fetch done");
  endtask
  task automatic test_pc();
    pc_target = 10'h2F0;
    pc_jump = 1;
    on_cyc();
    pc_jump = 0;
    chk({4'h0, pc}, 14'h02F0);
    pc_low_wdata = 8'h12;
    pc_low_wr = 1;
    on_cyc();
    pc_low_wr = 0;
    chk({4'h0, pc}, 14'h0212);
    pc_advance = 1;
    on_cyc();
    pc_advance = 0;
    tick(1);
    chk({6'h00, pc_low_byte}, 14'h0013);
    chk({6'h00, table_high_byte}, 14'h0012);
    $display("pc control done");
  endtask
  task automatic test_pins();
    debug_en = 1;
    debug_serial_clock = 1;
    prog_sda_out = 1;
    prog_sda_oe_n = 0;
    pin_func_out = 0;
    tick(2);
    chk({13'h0000, pin_data_out}, 14'h0001);
    chk({13'h0000, pin_data_oe_n}, 14'h0000);
    chk({13'h0000, debug_clk_seen}, 14'h0001);
    prog_sda_oe_n = 1;
    tick(2);
    chk({13'h0000, pin_data_oe_n}, 14'h0001);
    // Port function gets the pin back once debugging stops
    debug_en = 0;
    prog_sda_out = 0;
    pin_func_out = 1;
    tick(2);
    chk({13'h0000, pin_data_out}, 14'h0001);
    chk({13'h0000, pin_data_oe_n}, 14'h0000);
    chk({13'h0000, debug_clk_seen}, 14'h0000);
    debug_serial_clock = 0;
    $display("debug pin done");
  endtask
  // Held two edges so the hold checks see settled reset values
  task automatic test_reset();
    srst = 1;
    tick(2);
    srst = 0;
    tick(1);
    chk({4'h0, pc}, 14'h0000);
    chk({6'h00, table_high_byte}, 14'h0000);
    chk({13'h0000, tbl_busy}, 14'h0000);
    tick(7);
    chk({6'h00, pc_low_byte}, 14'h0000);
    chk(instr, 14'h1234);
    $display("mid run reset done");
  endtask

  initial begin
    tick(12);
    srst = 0;
    tick(1);
    chk({6'h00, table_high_byte}, 14'h0000);
    chk({4'h0, pc}, 14'h0000);
    test_load();
    tbl_read(2'h3, 8'h06, 1'b0, tw[0]);
    tbl_read(2'h0, 8'h05, 1'b1, tw[1]);
    tbl_read(2'h3, 8'hFF, 1'b0, tw[2]);
    tbl_read(2'h0, 8'h00, 1'b0, tw[3]);
    tick(9);
    chk({6'h00, table_high_byte}, 14'h0012);
    test_pc();
    test_pins();
    test_reset();
    stop_test();
  end
endmodule
